// >>> verilog/alb_pkg.sv
// Package for the arithmetic, logic and branch execution subset
// What this block does
// - Add accumulators, one cycle, accumulator flags only
// - Signed shifted word add into accumulator
// - Add with carry updates all word flags
// - AND forms update only negative and zero
// - Single-bit shift right updates carry, sign, overflow, zero
// - Multi-bit shift right updates only N, Z
// - Bit clear/set, 4-bit index, no flags
// - Conditional branch: 1 cycle, 4 taken
// - Branch on accumulator overflow or saturation
// - Unconditional branch always four cycles
// - Computed branch four cycles, no flags
// - Y prefetch W10/W11, post-modify, indexed, none
// - Peripheral register access adds one cycle to add, logic, shift and bit ops
package alb_pkg;

    localparam int ALB_DW       = 16;
    localparam int ALB_AW       = 40;
    localparam int ALB_SAT_BITS = 32;
    localparam int ALB_TAKEN_CYC  = 4;
    localparam int ALB_NORM_CYC   = 1;
    localparam logic [3:0] ALB_W10 = 4'hA;
    localparam logic [3:0] ALB_W11 = 4'hB;
    localparam logic [3:0] ALB_W12 = 4'hC;

    typedef enum logic [3:0] {
        ALB_OP_NOP   = 4'h0,
        ALB_OP_ADDAC = 4'h1,
        ALB_OP_ADDWA = 4'h2,
        ALB_OP_ADD   = 4'h3,
        ALB_OP_ADD_WITH_CARRY_OP  = 4'h4,
        ALB_OP_AND   = 4'h5,
        ALB_OP_ASR1  = 4'h6,
        ALB_OP_ASRN  = 4'h7,
        ALB_OP_BIT_CLEAR_OP  = 4'h8,
        ALB_OP_BIT_SET_OP  = 4'h9,
        ALB_OP_BRC   = 4'hA,
        ALB_OP_BRU   = 4'hB,
        ALB_OP_BRW   = 4'hC
    } alb_op_e;

    typedef enum logic [4:0] {
        ALB_CC_C   = 5'h00, ALB_CC_GE  = 5'h01, ALB_CC_GEU = 5'h02,
        ALB_CC_GT  = 5'h03, ALB_CC_GTU = 5'h04, ALB_CC_LE  = 5'h05,
        ALB_CC_LEU = 5'h06, ALB_CC_LT  = 5'h07, ALB_CC_LTU = 5'h08,
        ALB_CC_N   = 5'h09, ALB_CC_NC  = 5'h0A, ALB_CC_NN  = 5'h0B,
        ALB_CC_NOV = 5'h0C, ALB_CC_NZ  = 5'h0D, ALB_CC_OA  = 5'h0E,
        ALB_CC_OB  = 5'h0F, ALB_CC_OV  = 5'h10, ALB_CC_SA  = 5'h11,
        ALB_CC_SB  = 5'h12, ALB_CC_Z   = 5'h13
    } alb_cc_e;

    typedef enum logic [2:0] {
        ALB_YM_NONE = 3'h0, ALB_YM_PLAIN = 3'h1, ALB_YM_POST = 3'h2,
        ALB_YM_IDX  = 3'h3
    } alb_ymode_e;

    typedef struct packed {
        logic c;
        logic dc;
        logic n;
        logic ov;
        logic z;
        logic oa;
        logic ob;
        logic sa;
        logic sb;
    } alb_flags_s;

    localparam alb_flags_s ALB_FLAGS_RST = '0;

    typedef struct packed {
        alb_op_e          op;
        alb_cc_e          cc;
        logic             acc_sel;
        logic [15:0]      opa;
        logic [15:0]      opb;
        logic [3:0]       shamt;
        logic signed [3:0] slit4;
        logic [3:0]       bitno;
        logic             sfr_access;
        alb_ymode_e       ymode;
        logic             ysel;
        logic signed [2:0] ystep;
    } alb_instr_s;

    typedef struct packed {
        logic        ok;
        logic [3:0]  reg_no;
        logic        idx;
        logic signed [3:0] post;
    } alb_yfetch_s;

endpackage

// >>> verilog/alb_alu.sv
// Word datapath for add, add with carry, AND and shifts
`timescale 1ns/1ns
module alb_alu
    import alb_pkg::*;
(
    input  wire alb_op_e     op,
    input  wire logic [15:0] opa,
    input  wire logic [15:0] opb,
    input  wire logic [3:0]  shamt,
    input  wire logic        c_in,
    input  wire logic [3:0]  bitno,
    output logic [15:0]      res,
    output alb_flags_s       fl
);
    logic [16:0] sum;
    logic [4:0]  lo;
    logic        cin;
    logic [15:0] msk;

    always_comb
    begin
        cin = (op == ALB_OP_ADD_WITH_CARRY_OP) ? c_in : 1'b0;
        sum = {1'b0, opa} + {1'b0, opb} + {16'h0000, cin};
        lo  = {1'b0, opa[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
        msk = 16'h0001 << bitno;
        res = opa;
        fl  = '0;
        case (op)
            ALB_OP_ADD, ALB_OP_ADD_WITH_CARRY_OP:
            begin
                res   = sum[15:0];
                fl.c  = sum[16];
                fl.dc = lo[4];
                fl.ov = (opa[15] == opb[15]) && (sum[15] != opa[15]);
            end
            ALB_OP_AND:  res = opa & opb;
            ALB_OP_ASR1:
            begin
                res  = {opa[15], opa[15:1]};
                fl.c = opa[0];
            end
            ALB_OP_ASRN: res = 16'($signed(opa) >>> shamt);
            ALB_OP_BIT_CLEAR_OP: res = opa & ~msk;
            ALB_OP_BIT_SET_OP: res = opa | msk;
            default:     res = opa;
        endcase
        fl.n = res[15];
        fl.z = (res == 16'h0000);
    end
endmodule

// >>> verilog/alb_yfetch.sv
// Decode of the Y data space prefetch operand
`timescale 1ns/1ns
module alb_yfetch
    import alb_pkg::*;
(
    input  wire alb_ymode_e        ymode,
    input  wire logic              ysel,
    input  wire logic signed [2:0] ystep,
    output alb_yfetch_s            yf
);
    always_comb
    begin
        yf = '0;
        case (ymode)
            ALB_YM_PLAIN:
            begin
                yf.ok     = 1'b1;
                yf.reg_no = ysel ? ALB_W11 : ALB_W10;
            end
            ALB_YM_POST:
            begin
                yf.ok     = (ystep != 3'sd0) && (ystep != -3'sd4);
                yf.reg_no = ysel ? ALB_W11 : ALB_W10;
                yf.post   = 4'(ystep) <<< 1;
            end
            ALB_YM_IDX:
            begin
                yf.ok     = 1'b1;
                yf.reg_no = ALB_W11;
                yf.idx    = 1'b1;
            end
            ALB_YM_NONE: yf.ok = 1'b1;
            default:     yf = '0;
        endcase
    end
endmodule

// >>> verilog/alb_core.sv
// Execution unit for the arithmetic, logic and branch subset
`timescale 1ns/1ns
module alb_core
    import alb_pkg::*;
#(
    parameter int DW = ALB_DW
)
(
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic        issue,
    input  wire alb_instr_s  instr,
    output logic             ready_r,
    output logic             done_r,
    output logic             taken_r,
    output logic [15:0]      result_r,
    output logic [39:0]      acc_a_r,
    output logic [39:0]      acc_b_r,
    output alb_flags_s       flags_r,
    output alb_yfetch_s      yfetch_r
);
    initial
    begin
        if (DW != 16)
            $error("alb_core supports only a 16-bit data path");
    end

    typedef enum logic [2:0] {
        ALB_ST_IDLE = 3'b001,
        ALB_ST_WAIT = 3'b010,
        ALB_ST_DONE = 3'b100
    } alb_state_e;

    alb_state_e  st_r;
    alb_state_e  st_nxt;
    logic [2:0]  wait_r;
    logic [2:0]  wait_nxt;
    logic [15:0] alu_res;
    alb_flags_s  alu_fl;
    alb_yfetch_s yf;
    alb_flags_s  flags_nxt;
    logic        take;
    logic [2:0]  extra;
    logic [39:0] acc_sum;
    logic [39:0] acc_sat;
    logic        acc_ovf;
    logic        acc_satd;
    logic [39:0] src_acc;
    logic [39:0] add_acc;

    // Saturation limits for a 32-bit signed payload
    function automatic logic [39:0] sat40(input logic [39:0] v,
                                          output logic hit);
        logic [39:0] pos;
        logic [39:0] neg;
        pos = 40'h007FFFFFFF;
        neg = 40'hFF80000000;
        hit = 1'b0;
        if (!v[39] && v > pos)
        begin
            hit = 1'b1;
            return pos;
        end
        if (v[39] && v < neg)
        begin
            hit = 1'b1;
            return neg;
        end
        return v;
    endfunction

    alb_alu u_alu (
        .op    (instr.op),
        .opa   (instr.opa),
        .opb   (instr.opb),
        .shamt (instr.shamt),
        .c_in  (flags_r.c),
        .bitno (instr.bitno),
        .res   (alu_res),
        .fl    (alu_fl)
    );

    alb_yfetch u_yf (
        .ymode (instr.ymode),
        .ysel  (instr.ysel),
        .ystep (instr.ystep),
        .yf    (yf)
    );

    always_comb
    begin
        case (instr.cc)
            ALB_CC_C:   take = flags_r.c;
            ALB_CC_NC:  take = !flags_r.c;
            ALB_CC_N:   take = flags_r.n;
            ALB_CC_NN:  take = !flags_r.n;
            ALB_CC_OV:  take = flags_r.ov;
            ALB_CC_NOV: take = !flags_r.ov;
            ALB_CC_Z:   take = flags_r.z;
            ALB_CC_NZ:  take = !flags_r.z;
            ALB_CC_GE:  take = flags_r.n == flags_r.ov;
            ALB_CC_LT:  take = flags_r.n != flags_r.ov;
            ALB_CC_GT:  take = !flags_r.z && (flags_r.n == flags_r.ov);
            ALB_CC_LE:  take = flags_r.z || (flags_r.n != flags_r.ov);
            ALB_CC_GEU: take = flags_r.c;
            ALB_CC_LTU: take = !flags_r.c;
            ALB_CC_GTU: take = flags_r.c && !flags_r.z;
            ALB_CC_LEU: take = !flags_r.c || flags_r.z;
            ALB_CC_OA:  take = flags_r.oa;
            ALB_CC_OB:  take = flags_r.ob;
            ALB_CC_SA:  take = flags_r.sa;
            ALB_CC_SB:  take = flags_r.sb;
            default:    take = 1'b0;
        endcase
    end

    // Accumulator adder for both accumulator forms
    always_comb
    begin
        src_acc = instr.acc_sel ? acc_b_r : acc_a_r;
        add_acc = instr.acc_sel ? acc_a_r : acc_b_r;
        if (instr.op == ALB_OP_ADDWA)
        begin
            add_acc = {{8{instr.opa[15]}}, instr.opa, 16'h0000};
            if (instr.slit4 >= 0)
                add_acc = $signed(add_acc) >>> instr.slit4;
            else
                add_acc = add_acc << (-instr.slit4);
        end
        acc_sum = src_acc + add_acc;
        acc_ovf = (acc_sum[39:31] != {9{acc_sum[39]}});
        acc_sat = sat40(acc_sum, acc_satd);
    end

    // Flag next value
    always_comb
    begin
        flags_nxt = flags_r;
        case (instr.op)
            ALB_OP_ADDAC, ALB_OP_ADDWA:
            begin
                if (instr.acc_sel)
                begin
                    flags_nxt.ob = acc_ovf;
                    flags_nxt.sb = acc_satd;
                end
                else
                begin
                    flags_nxt.oa = acc_ovf;
                    flags_nxt.sa = acc_satd;
                end
            end
            ALB_OP_ADD, ALB_OP_ADD_WITH_CARRY_OP:
            begin
                flags_nxt.c  = alu_fl.c;
                flags_nxt.dc = alu_fl.dc;
                flags_nxt.n  = alu_fl.n;
                flags_nxt.ov = alu_fl.ov;
                flags_nxt.z  = alu_fl.z;
            end
            ALB_OP_ASR1:
            begin
                flags_nxt.c  = alu_fl.c;
                flags_nxt.n  = alu_fl.n;
                flags_nxt.ov = 1'b0;
                flags_nxt.z  = alu_fl.z;
            end
            ALB_OP_AND, ALB_OP_ASRN:
            begin
                flags_nxt.n = alu_fl.n;
                flags_nxt.z = alu_fl.z;
            end
            default: flags_nxt = flags_r;
        endcase
    end

    // Extra cycles beyond the first
    always_comb
    begin
        extra = 3'd0;
        case (instr.op)
            ALB_OP_BRC:
                extra = take ? 3'(ALB_TAKEN_CYC - ALB_NORM_CYC) : 3'd0;
            ALB_OP_BRU: extra = 3'(ALB_TAKEN_CYC - ALB_NORM_CYC);
            ALB_OP_BRW: extra = 3'(ALB_TAKEN_CYC - ALB_NORM_CYC);
            default:    extra = 3'd0;
        endcase
        if (instr.sfr_access && instr.op inside {ALB_OP_ADD, ALB_OP_ADD_WITH_CARRY_OP,
            ALB_OP_AND, ALB_OP_ASR1, ALB_OP_ASRN, ALB_OP_BIT_CLEAR_OP, ALB_OP_BIT_SET_OP})
            extra = extra + 3'd1;
    end

    // Sequencer
    always_comb
    begin
        st_nxt   = st_r;
        wait_nxt = wait_r;
        case (st_r)
            ALB_ST_IDLE:
            begin
                if (issue)
                begin
                    wait_nxt = extra;
                    st_nxt   = (extra == 3'd0) ? ALB_ST_DONE : ALB_ST_WAIT;
                end
            end
            ALB_ST_WAIT:
            begin
                wait_nxt = wait_r - 3'd1;
                if (wait_r == 3'd1)
                    st_nxt = ALB_ST_DONE;
            end
            ALB_ST_DONE: st_nxt = ALB_ST_IDLE;
            default:     st_nxt = ALB_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            st_r   <= ALB_ST_IDLE;
            wait_r <= 3'd0;
        end
        else
        begin
            st_r   <= st_nxt;
            wait_r <= wait_nxt;
        end
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            ready_r <= 1'b1;
        else
            ready_r <= (st_nxt == ALB_ST_IDLE);
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            done_r <= 1'b0;
        else
            done_r <= (st_nxt == ALB_ST_DONE);
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            flags_r <= ALB_FLAGS_RST;
        else if (issue && st_r == ALB_ST_IDLE)
            flags_r <= flags_nxt;
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            result_r <= 16'h0000;
            taken_r  <= 1'b0;
            yfetch_r <= '0;
        end
        else if (issue && st_r == ALB_ST_IDLE)
        begin
            result_r <= alu_res;
            taken_r  <= (instr.op == ALB_OP_BRC) ? take :
                        (instr.op == ALB_OP_BRU || instr.op == ALB_OP_BRW);
            yfetch_r <= yf;
        end
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            acc_a_r <= 40'h0000000000;
            acc_b_r <= 40'h0000000000;
        end
        else if (issue && st_r == ALB_ST_IDLE &&
                 (instr.op == ALB_OP_ADDAC || instr.op == ALB_OP_ADDWA))
        begin
            if (instr.acc_sel)
                acc_b_r <= acc_sat;
            else
                acc_a_r <= acc_sat;
        end
    end
endmodule

// >>> bench/alb_core_monitor.sv
// Concurrent checks on the execution unit ports
`timescale 1ns/1ns
module alb_core_monitor
    import alb_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        reset,
    input wire logic        issue,
    input wire alb_instr_s  instr,
    input wire logic        ready_r,
    input wire logic        done_r,
    input wire logic        taken_r,
    input wire logic [15:0] result_r,
    input wire logic [39:0] acc_a_r,
    input wire logic [39:0] acc_b_r,
    input wire alb_flags_s  flags_r,
    input wire alb_yfetch_s yfetch_r
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    logic    go;
    logic    dat;
    alb_op_e o;
    assign o   = instr.op;
    assign go  = issue && ready_r;
    assign dat = o >= ALB_OP_ADD && o <= ALB_OP_BIT_SET_OP;
    sequence s_long;
        !done_r [*3] ##1 done_r && taken_r;
    endsequence
    sequence s_short;
        done_r && !taken_r;
    endsequence
    AST_ONE_CYCLE: assert property (go && dat && !instr.sfr_access |=> done_r)
        else $error("data op not done in one cycle");
    AST_SFR_EXTRA: assert property (go && dat && instr.sfr_access
        |=> !done_r ##1 done_r)
        else $error("peripheral access not two cycles");
    AST_JUMP_FOUR: assert property (go && o == ALB_OP_BRU |=> s_long)
        else $error("jump not four cycles");
    AST_COMPUTED: assert property (go && o == ALB_OP_BRW |=> s_long)
        else $error("computed jump not four cycles");
    AST_COND_BR: assert property (go && o == ALB_OP_BRC
        |=> s_short or s_long)
        else $error("branch timing wrong");
    AST_BR_FLAGS: assert property (go && o >= ALB_OP_BRC
        |=> flags_r == $past(flags_r))
        else $error("branch changed flags");
    AST_BIT_FLAGS: assert property (go && (o == ALB_OP_BIT_CLEAR_OP || o == ALB_OP_BIT_SET_OP)
        |=> flags_r == $past(flags_r))
        else $error("bit op changed flags");
    AST_AND_FLAGS: assert property (go && o == ALB_OP_AND
        |=> result_r == $past(instr.opa & instr.opb)
        && flags_r.z == (result_r == 16'h0000) && flags_r.n == result_r[15]
        && {flags_r.c, flags_r.ov} == $past({flags_r.c, flags_r.ov}))
        else $error("logic op result or flags wrong");
    AST_ASRN_FLAGS: assert property (go && o == ALB_OP_ASRN
        |=> {flags_r.c, flags_r.ov} == $past({flags_r.c, flags_r.ov}))
        else $error("multi-bit shift changed c or ov");
    AST_ADD_WITH_CARRY_OP_SUM: assert property (go && o == ALB_OP_ADD_WITH_CARRY_OP
        |=> result_r == $past(instr.opa + instr.opb + 16'(flags_r.c)))
        else $error("carry add sum wrong");
    AST_ACC_FLAGS: assert property (go && o inside {ALB_OP_ADDAC, ALB_OP_ADDWA}
        |=> flags_r[8:4] == $past(flags_r[8:4]))
        else $error("accumulator op changed word flags");
endmodule
bind alb_core alb_core_monitor u_mon (.clk_sys(clk_sys), .reset(reset),
    .issue(issue), .instr(instr), .ready_r(ready_r), .done_r(done_r),
    .taken_r(taken_r), .result_r(result_r), .acc_a_r(acc_a_r),
    .acc_b_r(acc_b_r), .flags_r(flags_r), .yfetch_r(yfetch_r));

// >>> bench/alb_testbench.sv
// Self-checking bench for the execution unit
`timescale 1ns/1ns
module testbench
    import alb_pkg::*;
;
    logic        clk_sys;
    logic        reset;
    logic        issue;
    alb_instr_s  ins;
    logic        ready_r;
    logic        done_r;
    logic        taken_r;
    logic [15:0] result_r;
    logic [39:0] acc_a_r;
    logic [39:0] acc_b_r;
    alb_flags_s  flags_r;
    alb_yfetch_s yfetch_r;
    int          mismatches;
    int          n_compared;
    int          cyc;
    alb_core DUT (.clk_sys(clk_sys), .reset(reset), .issue(issue),
        .instr(ins), .ready_r(ready_r), .done_r(done_r), .taken_r(taken_r),
        .result_r(result_r), .acc_a_r(acc_a_r), .acc_b_r(acc_b_r),
        .flags_r(flags_r), .yfetch_r(yfetch_r));
    task automatic chk_v(input logic [39:0] g, input logic [39:0] e);
        n_compared++;
        if (g !== e)
        begin
            mismatches++;
            $display("mismatch %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic tick;
        @(posedge clk_sys);
        #1;
    endtask
    task automatic idle;
        for (int k = 0; k < 20 && ready_r !== 1'b1; k++)
            tick;
    endtask
    task automatic fin;
        while (done_r !== 1'b1 && cyc < 20)
        begin
            tick;
            cyc++;
        end
    endtask
    task automatic run(input alb_op_e op, input logic [15:0] a, b);
        idle;
        ins.op = op;
        ins.opa = a;
        ins.opb = b;
        issue = 1'b1;
        tick;
        issue = 1'b0;
        cyc = 1;
        fin;
    endtask
    function automatic logic cond(input alb_cc_e cc, input alb_flags_s f);
        logic [19:0] t;
        logic        x;
        x = f.n ^ f.ov;
        t = {f.z, f.sb, f.sa, f.ov, f.ob, f.oa, !f.z, !f.ov, !f.n, !f.c,
             f.n, !f.c, x, !f.c | f.z, f.z | x, f.c & !f.z, !f.z & !x,
             f.c, !x, f.c};
        return t[cc];
    endfunction
    task automatic t_reset;
        chk_v(40'({ready_r, done_r, taken_r, flags_r}), 40'h800);
        chk_v(acc_a_r | acc_b_r | 40'(result_r), 40'h0);
    endtask
    task automatic t_arith;
        run(ALB_OP_ADD, 16'hFFFF, 16'h0001);
        chk_v(40'(flags_r), 40'h190);
        run(ALB_OP_ADD_WITH_CARRY_OP, 16'h7FFF, 16'h0000);
        chk_v(40'(result_r), 40'h8000);
        chk_v(40'(flags_r), 40'h0E0);
    endtask
    task automatic t_logic;
        run(ALB_OP_AND, 16'h00F0, 16'h0F0F);
        chk_v(40'({result_r, flags_r}), 40'h0B0);
        ins.shamt = 4'h4;
        run(ALB_OP_ASRN, 16'h8000, 16'h0000);
        chk_v(40'({result_r, flags_r}), 40'h1F000E0);
        run(ALB_OP_ASR1, 16'h8001, 16'h0000);
        chk_v(40'({result_r, flags_r}), 40'h18001C0);
        ins.bitno = 4'hF;
        run(ALB_OP_BIT_SET_OP, 16'h0000, 16'h0000);
        chk_v(40'({result_r, flags_r}), 40'h10001C0);
        ins.bitno = 4'h0;
        run(ALB_OP_BIT_CLEAR_OP, 16'hFFFF, 16'h0000);
        chk_v(40'({result_r, flags_r}), 40'h1FFFDC0);
        ins.sfr_access = 1'b1;
        run(ALB_OP_AND, 16'hFFFF, 16'h0001);
        chk_v(40'(cyc), 40'h2);
        run(ALB_OP_BIT_SET_OP, 16'h0000, 16'h0000);
        chk_v(40'(cyc), 40'h2);
        ins.sfr_access = 1'b0;
    endtask
    task automatic t_jump;
        run(ALB_OP_BRW, 16'h1234, 16'h0000);
        chk_v(40'({cyc[3:0], taken_r}), 40'h9);
        idle;
        ins.op = ALB_OP_BRU;
        issue = 1'b1;
        tick;
        ins.op = ALB_OP_ADD;
        ins.opa = 16'h5555;
        tick;
        tick;
        issue = 1'b0;
        cyc = 3;
        fin;
        chk_v(40'({cyc[3:0], taken_r}), 40'h9);
        chk_v(40'(result_r), 40'h1234);
    endtask
    task automatic t_acc;
        ins.acc_sel = 1'b0;
        run(ALB_OP_ADDWA, 16'h0001, 16'h0000);
        ins.acc_sel = 1'b1;
        run(ALB_OP_ADDWA, 16'h7FFF, 16'h0000);
        chk_v(acc_a_r, 40'h0000010000);
        chk_v(acc_b_r, 40'h007FFF0000);
        ins.acc_sel = 1'b0;
        run(ALB_OP_ADDAC, 16'h0000, 16'h0000);
        chk_v(acc_a_r, 40'h007FFFFFFF);
        chk_v(40'({flags_r[8:4], flags_r.sa}), 40'h31);
        chk_v(40'(cyc), 40'h1);
    endtask
    task automatic t_branch(input logic [15:0] a);
        logic e;
        run(ALB_OP_ADD, a, 16'h0001);
        for (int i = 0; i < 20; i++)
        begin
            ins.cc = alb_cc_e'(5'(i));
            e = cond(ins.cc, flags_r);
            run(ALB_OP_BRC, a, a);
            chk_v(40'(taken_r), 40'(e));
            chk_v(40'(cyc), e ? 40'h4 : 40'h1);
        end
    endtask
    task automatic ty(input alb_ymode_e m, input logic s,
                      input logic [2:0] st, input logic [9:0] e);
        ins.ymode = m;
        ins.ysel = s;
        ins.ystep = st;
        run(ALB_OP_ADDWA, 16'h0000, 16'h0000);
        chk_v(40'(yfetch_r), 40'(e));
    endtask
    task automatic t_yfetch;
        ty(ALB_YM_POST, 1'b1, 3'h3, 10'h366);
        ty(ALB_YM_POST, 1'b0, 3'h5, 10'h34A);
        ty(ALB_YM_PLAIN, 1'b0, 3'h0, 10'h340);
        ty(ALB_YM_IDX, 1'b1, 3'h0, 10'h370);
        ty(ALB_YM_NONE, 1'b0, 3'h0, 10'h200);
        ins.ymode = ALB_YM_POST;
        run(ALB_OP_ADDWA, 16'h0000, 16'h0000);
        chk_v(40'(yfetch_r.ok), 40'h0);
        ins.ystep = 3'h4;
        run(ALB_OP_ADDWA, 16'h0000, 16'h0000);
        chk_v(40'(yfetch_r.ok), 40'h0);
    endtask
    task automatic end_of_test;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    initial
    begin
        #1000000;
        mismatches++;
        end_of_test;
    end
    initial
    begin
        reset = 1'b1;
        issue = 1'b0;
        ins = '0;
        mismatches = 0;
        n_compared = 0;
        repeat (10) @(posedge clk_sys);
        #1;
        reset = 1'b0;
        t_reset;
        t_arith;
        t_logic;
        t_jump;
        t_acc;
        t_branch(16'hFFFF);
        t_branch(16'h7FFF);
        t_yfetch;
        end_of_test;
    end
endmodule
